// file: shared/rate_gen_pkg.sv
// Register map, field positions, reset values and divider limits of the rate generator.
package rate_gen_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DIV_W  = 16;
    localparam int unsigned PRE_W  = 2;
    localparam int unsigned POST_W = 4;

    localparam logic [ADDR_W-1:0] OFF_BAUD_CONTROL            = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_RECEIVE_CONTROL_STATUS  = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_RATE_DIVISOR_LOW        = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_RATE_DIVISOR_HIGH       = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_TRANSMIT_CONTROL_STATUS = 3'h4;

    // baud_control fields.
    localparam int unsigned BC_AUTO_BAUD_OVERFLOW = 7;
    localparam int unsigned BC_RECEIVER_IDLE      = 6;
    localparam int unsigned BC_CLOCK_POLARITY     = 4;
    localparam int unsigned BC_WIDE_DIVIDER       = 3;
    localparam int unsigned BC_WAKE_ENABLE        = 1;
    localparam int unsigned BC_AUTO_BAUD_ENABLE   = 0;
    localparam logic [DATA_W-1:0] BC_WRITE_MASK   = 8'h1b;

    // receive_control_status fields.
    localparam int unsigned RC_PORT_ENABLE        = 7;
    localparam logic [DATA_W-1:0] RC_WRITE_MASK   = 8'hf8;

    // transmit_control_status fields.
    localparam int unsigned TC_SYNC_MODE          = 4;
    localparam int unsigned TC_HIGH_SPEED         = 2;
    localparam int unsigned TC_SHIFT_EMPTY        = 1;
    localparam logic [DATA_W-1:0] TC_WRITE_MASK   = 8'hfd;

    localparam logic [DATA_W-1:0] RESET_BYTE      = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED   = 8'h00;

    // Oscillator cycles per timer count, and bit-rate post divisions (limit is ratio minus one).
    localparam logic [PRE_W-1:0]  PRE_LIMIT       = 2'h3;
    localparam logic [POST_W-1:0] POST_LIMIT_X16  = 4'hf;
    localparam logic [POST_W-1:0] POST_LIMIT_X4   = 4'h3;
    localparam logic [POST_W-1:0] POST_LIMIT_X1   = 4'h0;

endpackage

// file: rtl/rate_byte_reg.sv
// One software byte register with a per-bit write mask.
`timescale 1ns/1ps
module rate_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK  = 8'hff
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_write,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_value
);

    logic [7:0] value;
    logic [7:0] next_value;

    always_comb begin
        next_value = value;
        if (i_write) begin
            next_value = (i_wdata & WRITE_MASK) | (value & ~WRITE_MASK);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            value <= RESET_VALUE;
        end else begin
            value <= next_value;
        end
    end

    assign o_value = value;

endmodule

// file: rtl/rate_mod_counter.sv
// Up counter that wraps to zero after reaching a programmable limit.
`timescale 1ns/1ps
module rate_mod_counter #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_clear,
    input  wire logic             i_step,
    input  wire logic [WIDTH-1:0] i_limit,
    output logic      [WIDTH-1:0] o_count,
    output logic                  o_wrap
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // A limit lowered below the count wraps at once instead of running round the full range.
    always_comb begin
        next_count = count;
        if (i_clear) begin
            next_count = '0;
        end else if (i_step) begin
            if (count >= i_limit) begin
                next_count = '0;
            end else begin
                next_count = count + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_count = count;
    assign o_wrap  = i_step && !i_clear && (count >= i_limit);

endmodule

// file: rtl/serial_baud_rate_generator.sv
// Bit-rate timer of a serial port with its control registers.
`timescale 1ns/1ps
module serial_baud_rate_generator (
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_arst_n,
    input  wire logic [rate_gen_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [rate_gen_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                             i_wr,
    input  wire logic                             i_rd,
    input  wire logic                             i_receiver_idle_flag,
    input  wire logic                             i_tx_shift_empty,
    output logic      [rate_gen_pkg::DATA_W-1:0]  o_rdata,
    output logic                                  o_rate_tick,
    output logic                                  o_bit_tick,
    output logic                                  o_sync_mode,
    output logic                                  o_high_speed_select,
    output logic                                  o_wide_divider_select
);

    logic [7:0] baud_control;
    logic [7:0] receive_control_status;
    logic [7:0] rate_divisor_low;
    logic [7:0] rate_divisor_high;
    logic [7:0] transmit_control_status;

    logic wr_baud;
    logic wr_receive;
    logic wr_low;
    logic wr_high;
    logic wr_transmit;

    logic sync_mode;
    logic high_speed_select;
    logic wide_divider_select;

    logic [rate_gen_pkg::DIV_W-1:0]  period;
    logic [rate_gen_pkg::POST_W-1:0] post_limit;
    logic                            divisor_written;

    logic pre_wrap;
    logic timer_wrap;
    logic post_wrap;

    logic [rate_gen_pkg::DATA_W-1:0] read_value;
    logic [rate_gen_pkg::DATA_W-1:0] next_rdata;
    logic                            next_rate_tick;
    logic                            next_bit_tick;

    // Write decode.
    always_comb begin
        wr_baud     = 1'b0;
        wr_receive  = 1'b0;
        wr_low      = 1'b0;
        wr_high     = 1'b0;
        wr_transmit = 1'b0;
        if (i_wr) begin
            if (i_addr == rate_gen_pkg::OFF_BAUD_CONTROL) begin
                wr_baud = 1'b1;
            end else if (i_addr == rate_gen_pkg::OFF_RECEIVE_CONTROL_STATUS) begin
                wr_receive = 1'b1;
            end else if (i_addr == rate_gen_pkg::OFF_RATE_DIVISOR_LOW) begin
                wr_low = 1'b1;
            end else if (i_addr == rate_gen_pkg::OFF_RATE_DIVISOR_HIGH) begin
                wr_high = 1'b1;
            end else if (i_addr == rate_gen_pkg::OFF_TRANSMIT_CONTROL_STATUS) begin
                wr_transmit = 1'b1;
            end
        end
    end

    rate_byte_reg #(
        .RESET_VALUE (rate_gen_pkg::RESET_BYTE),
        .WRITE_MASK  (rate_gen_pkg::BC_WRITE_MASK)
    ) u_baud_control (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_write   (wr_baud),
        .i_wdata   (i_wdata),
        .o_value   (baud_control)
    );

    rate_byte_reg #(
        .RESET_VALUE (rate_gen_pkg::RESET_BYTE),
        .WRITE_MASK  (rate_gen_pkg::RC_WRITE_MASK)
    ) u_receive_control_status (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_write   (wr_receive),
        .i_wdata   (i_wdata),
        .o_value   (receive_control_status)
    );

    rate_byte_reg #(
        .RESET_VALUE (rate_gen_pkg::RESET_BYTE),
        .WRITE_MASK  (8'hff)
    ) u_rate_divisor_low (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_write   (wr_low),
        .i_wdata   (i_wdata),
        .o_value   (rate_divisor_low)
    );

    rate_byte_reg #(
        .RESET_VALUE (rate_gen_pkg::RESET_BYTE),
        .WRITE_MASK  (8'hff)
    ) u_rate_divisor_high (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_write   (wr_high),
        .i_wdata   (i_wdata),
        .o_value   (rate_divisor_high)
    );

    rate_byte_reg #(
        .RESET_VALUE (rate_gen_pkg::RESET_BYTE),
        .WRITE_MASK  (rate_gen_pkg::TC_WRITE_MASK)
    ) u_transmit_control_status (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_write   (wr_transmit),
        .i_wdata   (i_wdata),
        .o_value   (transmit_control_status)
    );

    assign sync_mode           = transmit_control_status[rate_gen_pkg::TC_SYNC_MODE];
    assign high_speed_select   = transmit_control_status[rate_gen_pkg::TC_HIGH_SPEED];
    assign wide_divider_select = baud_control[rate_gen_pkg::BC_WIDE_DIVIDER];

    // Timer period and bit-rate multiplier.
    always_comb begin
        divisor_written = wr_low || wr_high;
        if (wide_divider_select) begin
            period = {rate_divisor_high, rate_divisor_low};
        end else begin
            period = {8'h00, rate_divisor_low};
        end
        // The timer alone gives four oscillator cycles per count; the rest is post division.
        if (sync_mode) begin
            post_limit = rate_gen_pkg::POST_LIMIT_X1;
        end else if (!wide_divider_select && !high_speed_select) begin
            post_limit = rate_gen_pkg::POST_LIMIT_X16;
        end else if (wide_divider_select && high_speed_select) begin
            post_limit = rate_gen_pkg::POST_LIMIT_X1;
        end else begin
            post_limit = rate_gen_pkg::POST_LIMIT_X4;
        end
    end

    // Free-running chain; a divisor write restarts all three stages together.
    rate_mod_counter #(
        .WIDTH (rate_gen_pkg::PRE_W)
    ) u_prescaler (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clear   (divisor_written),
        .i_step    (1'b1),
        .i_limit   (rate_gen_pkg::PRE_LIMIT),
        .o_count   (),
        .o_wrap    (pre_wrap)
    );

    rate_mod_counter #(
        .WIDTH (rate_gen_pkg::DIV_W)
    ) u_rate_divider_timer (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clear   (divisor_written),
        .i_step    (pre_wrap),
        .i_limit   (period),
        .o_count   (),
        .o_wrap    (timer_wrap)
    );

    rate_mod_counter #(
        .WIDTH (rate_gen_pkg::POST_W)
    ) u_post_divider (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_clear   (divisor_written),
        .i_step    (timer_wrap),
        .i_limit   (post_limit),
        .o_count   (),
        .o_wrap    (post_wrap)
    );

    // Read mux; status bits owned by the shift logic are sampled live.
    always_comb begin
        read_value = rate_gen_pkg::READ_UNMAPPED;
        if (i_addr == rate_gen_pkg::OFF_BAUD_CONTROL) begin
            read_value = baud_control & rate_gen_pkg::BC_WRITE_MASK;
            read_value[rate_gen_pkg::BC_RECEIVER_IDLE] = i_receiver_idle_flag;
        end else if (i_addr == rate_gen_pkg::OFF_RECEIVE_CONTROL_STATUS) begin
            read_value = receive_control_status & rate_gen_pkg::RC_WRITE_MASK;
        end else if (i_addr == rate_gen_pkg::OFF_RATE_DIVISOR_LOW) begin
            read_value = rate_divisor_low;
        end else if (i_addr == rate_gen_pkg::OFF_RATE_DIVISOR_HIGH) begin
            read_value = rate_divisor_high;
        end else if (i_addr == rate_gen_pkg::OFF_TRANSMIT_CONTROL_STATUS) begin
            read_value = transmit_control_status & rate_gen_pkg::TC_WRITE_MASK;
            read_value[rate_gen_pkg::TC_SHIFT_EMPTY] = i_tx_shift_empty;
        end
    end

    always_comb begin
        next_rdata     = i_rd ? read_value : rate_gen_pkg::READ_UNMAPPED;
        next_rate_tick = timer_wrap;
        next_bit_tick  = post_wrap;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata     <= rate_gen_pkg::READ_UNMAPPED;
            o_rate_tick <= 1'b0;
            o_bit_tick  <= 1'b0;
        end else begin
            o_rdata     <= next_rdata;
            o_rate_tick <= next_rate_tick;
            o_bit_tick  <= next_bit_tick;
        end
    end

    assign o_sync_mode           = sync_mode;
    assign o_high_speed_select   = high_speed_select;
    assign o_wide_divider_select = wide_divider_select;

endmodule

// file: verif/rate_gen_monitor.sv
// Port-level checker of the rate generator, bound to its top module.
`timescale 1ns/1ps
module rate_gen_monitor (
    input wire logic       i_sys_clk,
    input wire logic       i_arst_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rate_tick,
    input wire logic       o_bit_tick,
    input wire logic       o_sync_mode,
    input wire logic       o_high_speed_select,
    input wire logic       o_wide_divider_select
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    wire div_wr = i_wr && (i_addr == 3'h2 || i_addr == 3'h3);
    logic prev_sync;
    logic prev_sync_hs;
    logic prev_fast;
    // Ticks leave the multiplier a cycle after the selects, so the checks use last cycle's selects.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_sync    <= 1'b0;
            prev_sync_hs <= 1'b0;
            prev_fast    <= 1'b0;
        end else begin
            prev_sync    <= o_sync_mode;
            prev_sync_hs <= o_sync_mode && o_high_speed_select;
            prev_fast    <= !o_sync_mode && o_wide_divider_select && o_high_speed_select;
        end
    end
    a_clear_on_write: assert property (div_wr |=> !o_rate_tick [*4])
        else $error("rate tick too soon after divisor write");
    a_rate_gap: assert property (o_rate_tick |=> !o_rate_tick [*3])
        else $error("rate ticks closer than four cycles");
    a_bit_on_rate: assert property (o_bit_tick |-> o_rate_tick)
        else $error("bit tick without timer overflow");
    a_sync_rate: assert property (prev_sync && o_rate_tick |-> o_bit_tick)
        else $error("sync mode missed a bit tick");
    a_sync_ignores_hs: assert property (prev_sync_hs && o_rate_tick |-> o_bit_tick)
        else $error("high speed select changed sync rate");
    a_fast_async: assert property (prev_fast && o_rate_tick |-> o_bit_tick)
        else $error("wide high speed rate wrong");
    a_mode_follow: assert property (i_wr && i_addr == 3'h4 |=>
        o_sync_mode == $past(i_wdata[4]) && o_high_speed_select == $past(i_wdata[2]))
        else $error("mode selects do not follow write");
    a_wide_follow: assert property (i_wr && i_addr == 3'h0 |=>
        o_wide_divider_select == $past(i_wdata[3]))
        else $error("width select does not follow write");
    a_bit_pulse: assert property (o_bit_tick |=> !o_bit_tick)
        else $error("bit tick longer than one cycle");
    cover property (o_bit_tick && o_sync_mode);
    cover property (o_bit_tick && o_wide_divider_select && !o_sync_mode);
    cover property ($past(i_rd) && o_rdata != 8'h00);
endmodule

bind serial_baud_rate_generator rate_gen_monitor i_rate_gen_monitor (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rate_tick(o_rate_tick),
    .o_bit_tick(o_bit_tick), .o_sync_mode(o_sync_mode),
    .o_high_speed_select(o_high_speed_select), .o_wide_divider_select(o_wide_divider_select));

// file: verif/serial_shift_model.sv
// Behavioural shift logic that consumes bit ticks and reports its status lines.
`timescale 1ns/1ps
module serial_shift_model (
    input  wire logic i_sys_clk,
    input  wire logic i_arst_n,
    input  wire logic i_bit_tick,
    output logic      o_receiver_idle_flag,
    output logic      o_tx_shift_empty
);
    logic [3:0] bit_count;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bit_count <= 4'h0;
        end else if (i_bit_tick) begin
            bit_count <= bit_count + 4'h1;
        end
    end
    // Both status lines spend part of each frame busy, so software sees both levels.
    assign o_receiver_idle_flag = (bit_count[3:1] != 3'h1);
    assign o_tx_shift_empty     = !bit_count[3];
endmodule

// file: verif/tb.sv
// Self-checking bench for the register map and divider modes of the rate generator.
`timescale 1ns/1ps
module tb;
    logic        i_sys_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic [2:0]  i_addr = 3'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        idle, empty, rate_tick, bit_tick, sync_mode, hs, wide;
    logic        rd_seen, wr_div;
    logic [1:0]  live;
    logic [2:0]  a_seen, m;
    logic [7:0]  rdata, lo, exp;
    logic [15:0] n;
    logic [7:0]  shadow [8];
    logic [7:0]  read_q [$];
    logic [15:0] tick_q [$];
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          gap = 0;
    int          mul;
    int          rates = 0;
    int          mul_q [$];

    serial_baud_rate_generator i_serial_baud_rate_generator (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_receiver_idle_flag(idle), .i_tx_shift_empty(empty),
        .o_rdata(rdata), .o_rate_tick(rate_tick), .o_bit_tick(bit_tick),
        .o_sync_mode(sync_mode), .o_high_speed_select(hs), .o_wide_divider_select(wide));
    serial_shift_model i_serial_shift_model (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_bit_tick(bit_tick),
        .o_receiver_idle_flag(idle), .o_tx_shift_empty(empty));

    initial begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    function automatic logic [7:0] mask(input logic [2:0] a);
        case (a)
            3'h0: mask = rate_gen_pkg::BC_WRITE_MASK;
            3'h1: mask = rate_gen_pkg::RC_WRITE_MASK;
            3'h2, 3'h3: mask = 8'hff;
            3'h4: mask = rate_gen_pkg::TC_WRITE_MASK;
            default: mask = rate_gen_pkg::READ_UNMAPPED;
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] expect_v);
        samples_checked++;
        if (seen !== expect_v) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expect_v);
        end
    endtask

    task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        if (w) shadow[a] = d & mask(a);
        if (r) read_q.push_back(shadow[a]);
        @(posedge i_sys_clk);
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Inputs are sampled at the edge, outputs just after it once the registers have landed.
    always begin
        @(posedge i_sys_clk);
        rd_seen = i_rd;
        a_seen = i_addr;
        live = {idle, empty};
        wr_div = i_wr && i_addr[2:1] == 2'b01;
        #1;
        if (rd_seen) begin
            exp = read_q.pop_front();
            if (a_seen == 3'h0) exp[6] = live[1];
            if (a_seen == 3'h4) exp[1] = live[0];
            check({8'h00, rdata}, {8'h00, exp});
        end
        gap = wr_div ? 0 : gap + 1;
        if (wr_div) begin
            rates = 0;
        end else if (rate_tick === 1'b1) begin
            rates++;
        end
        if (bit_tick === 1'b1) begin
            if (tick_q.size() > 0) begin
                check(gap[15:0], tick_q.pop_front());
                check(rates[15:0], 16'(mul_q.pop_front()));
            end
            gap = 0;
            rates = 0;
        end
    end

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        void'($urandom(32'h0d6463ed));
        for (int k = 0; k < 8; k++) shadow[k] = rate_gen_pkg::RESET_BYTE;
        repeat (16) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        @(posedge i_sys_clk);
        for (int k = 0; k < 6; k++) cyc(1'b0, 1'b1, k[2:0], 8'h00);
        for (int k = 0; k < 8; k++) begin
            cyc(1'b1, 1'b0, k[2:0], 8'($urandom));
            cyc(1'b0, 1'b1, k[2:0], 8'h00);
        end
        cyc(1'b0, 1'b0, 3'h0, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            m = i[2:0];
            lo = (i == 8) ? 8'd51 : 8'($urandom % 8);
            mul = (m[2] || (m[1] && m[0])) ? 1 : ((m[1] || m[0]) ? 4 : 16);
            n = 16'(4 * ((m[1] ? 256 : 0) + lo + 1) * mul);
            cyc(1'b1, 1'b0, 3'h4, {3'h0, m[2], 1'b0, m[0], 2'h0});
            cyc(1'b1, 1'b0, 3'h0, {4'h0, m[1], 3'h0});
            cyc(1'b1, 1'b0, 3'h3, 8'h01);
            cyc(1'b1, 1'b0, 3'h2, lo);
            cyc(1'b0, 1'b0, 3'h0, 8'h00);
            check({13'h0000, sync_mode, wide, hs}, {13'h0000, m});
            tick_q.push_back(n);
            tick_q.push_back(n);
            mul_q.push_back(mul);
            mul_q.push_back(mul);
            wait (tick_q.size() == 0);
            @(posedge i_sys_clk);
            $display("test rate mode %0d done", i);
        end
        results();
    end
endmodule
